/* src/smap_bank.sv */
// smap_bank: core special function registers, pointer select and area decode
// assumes single-cycle strobes that never overlap; read data the cycle after
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module smap_bank
    import smap_pkg::*;
#(
    parameter int NPTR = PTR_COUNT,
    parameter int SELW = 3
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              resetPinB,
    input  wire logic              programEnablePin,
    input  wire logic              portDirMapBit,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic              bitSet,
    input  wire logic              bitClr,
    input  wire logic [BIDX_W-1:0] bitIdx,
    output logic      [DATA_W-1:0] regRdData_q,
    output logic                   regRdBit_q,
    output logic      [PTR_W-1:0]  activePointer_q,
    output logic                   sfrMapSelect_q,
    output logic                   accessMapped_q,
    output logic                   accessPdirAlt_q,
    output logic                   coreResetB_q
);

    if (NPTR != 2 ** SELW || SELW > BIDX_W) begin : g_bad_ptr
        $error("smap_bank: pointer count must be a power of two up to 8");
    end

    logic              syncStage1_q;
    logic              coreRunning_q;
    logic              rstCore;
    logic              eCapture;
    logic [7:0]        stackPointer_q;
    logic [SELW-1:0]   pointerSelect_q;
    logic [7:0]        systemControl_q;
    logic [7:0]        systemControlTwo_q;
    logic [7:0]        programStatusWord_q;
    logic [7:0]        arithResultReg_q;
    logic [7:0]        auxOperand_q;
    logic [PTR_W-1:0]  ptrVal [NPTR];
    logic [PTR_W-1:0]  selPtr;
    logic [PTR_W-1:0]  otherPtr;
    logic [7:0]        curByte;
    logic [7:0]        bitMask;
    logic              bitOp;
    logic              wrStb;
    logic [7:0]        wrVal;
    logic              isMapped;
    logic              isPdirAlt;

    // reset pin synchroniser; second stage is the core reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncStage1_q <= 1'b0;
            coreResetB_q <= 1'b0;
        end else begin
            syncStage1_q <= resetPinB;                                  // [RQ2]
            coreResetB_q <= syncStage1_q;                               // [RQ2]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreRunning_q <= 1'b0;
        end else begin
            coreRunning_q <= coreResetB_q;
        end
    end

    assign rstCore  = !coreResetB_q;
    assign eCapture = coreResetB_q && !coreRunning_q;                   // [RQ15]

    // decode; shared addresses resolved by map select or port direction bit
    assign isMapped  = sfrMapSelect_q && smap_is_mappable(regAddr);    // [RQ6] [RQ8] [RQ10]
    assign isPdirAlt = (regAddr == ADR_PORT_DIRECTION_MAP_BIT_ALT) && portDirMapBit;     // [RQ10]

    assign selPtr   = ptrVal[pointerSelect_q];                          // [RQ4]
    assign otherPtr = ptrVal[SELW'(pointerSelect_q + 1'b1)];

    // standard-area read view of the bank; others read zero
    always_comb begin
        curByte = RST_ZERO;
        if (!isMapped) begin                                            // [RQ9]
            case (regAddr)
                ADR_SP:    curByte = stackPointer_q;
                ADR_DPL:   curByte = selPtr[DATA_W-1:0];                // [RQ5]
                ADR_DPH:   curByte = selPtr[PTR_W-1:DATA_W];            // [RQ5]
                ADR_PSEL:  curByte = 8'(pointerSelect_q);
                ADR_SYSC:  curByte = systemControl_q;
                ADR_SYSC2: curByte = systemControlTwo_q;
                ADR_PSW:   curByte = programStatusWord_q;
                ADR_ACC:   curByte = arithResultReg_q;
                ADR_AUX:   curByte = auxOperand_q;
                default:   curByte = RST_ZERO;
            endcase
        end
    end

    // single-bit operations fold into one byte write
    assign bitMask = 8'h01 << bitIdx;
    assign bitOp   = (bitSet || bitClr) && smap_is_bit_reg(regAddr);   // [RQ16]
    assign wrStb   = (regWr || bitOp) && !isMapped && !rstCore;
    always_comb begin
        if (regWr) begin
            wrVal = regWrData;
        end else if (bitSet) begin
            wrVal = curByte | bitMask;                                  // [RQ16]
        end else begin
            wrVal = curByte & ~bitMask;                                 // [RQ16]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stackPointer_q <= RST_SP;
        end else if (rstCore) begin
            stackPointer_q <= RST_SP;                                   // [RQ12]
        end else if (wrStb && regAddr == ADR_SP) begin
            stackPointer_q <= wrVal;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pointerSelect_q <= SELW'(RST_PSEL);
        end else if (rstCore) begin
            pointerSelect_q <= SELW'(RST_PSEL);                         // [RQ13]
        end else if (wrStb && regAddr == ADR_PSEL) begin
            pointerSelect_q <= wrVal[SELW-1:0];                         // [RQ4]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            systemControl_q <= RST_SYSC;
        end else if (rstCore) begin
            systemControl_q <= RST_SYSC;                                // [RQ11]
        end else if (wrStb && regAddr == ADR_SYSC) begin
            systemControl_q <= (wrVal & SYSC_RW_MASK) | SYSC_FIX_MASK; // [RQ11] [RQ7]
        end
    end
    assign sfrMapSelect_q = systemControl_q[SYSC_MAP_BIT];             // [RQ6]

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            systemControlTwo_q <= RST_SYSC2;
        end else if (rstCore) begin
            systemControlTwo_q <= RST_SYSC2;                            // [RQ14]
        end else if (eCapture) begin
            systemControlTwo_q[SYSC2_E_HI:SYSC2_E_LO] <= {2{programEnablePin}}; // [RQ15]
        end else if (wrStb && regAddr == ADR_SYSC2) begin
            systemControlTwo_q <= wrVal & SYSC2_RW_MASK;                // [RQ14]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            programStatusWord_q <= RST_ZERO;
            arithResultReg_q    <= RST_ZERO;
            auxOperand_q        <= RST_ZERO;
        end else if (rstCore) begin
            programStatusWord_q <= RST_ZERO;                            // [RQ12]
            arithResultReg_q    <= RST_ZERO;
            auxOperand_q        <= RST_ZERO;
        end else if (wrStb) begin
            if (regAddr == ADR_PSW) begin
                programStatusWord_q <= wrVal;
            end
            if (regAddr == ADR_ACC) begin
                arithResultReg_q <= wrVal;
            end
            if (regAddr == ADR_AUX) begin
                auxOperand_q <= wrVal;
            end
        end
    end

    // eight pointers; only the selected one sees byte writes
    for (genvar i = 0; i < NPTR; i++) begin : g_ptr
        smap_dptr #(
            .PW      (PTR_W)
        ) u_dptr (
            .ref_clk (ref_clk),
            .rst_b   (rst_b),
            .clrReq  (rstCore),
            .wrLow   (wrStb && regAddr == ADR_DPL && pointerSelect_q == SELW'(i)), // [RQ3] [RQ5]
            .wrHigh  (wrStb && regAddr == ADR_DPH && pointerSelect_q == SELW'(i)), // [RQ3] [RQ5]
            .wrData  (wrVal),
            .value   (ptrVal[i])
        );
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            activePointer_q <= {RST_ZERO, RST_ZERO};
        end else begin
            activePointer_q <= selPtr;                                  // [RQ4]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_q <= RST_ZERO;
            regRdBit_q  <= 1'b0;
        end else if (regRd) begin
            regRdData_q <= curByte;
            regRdBit_q  <= curByte[bitIdx];                             // [RQ16]
        end
    end

    // one-cycle area flags for the access just made
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accessMapped_q  <= 1'b0;
            accessPdirAlt_q <= 1'b0;
        end else begin
            accessMapped_q  <= (regRd || regWr) && isMapped;            // [RQ8]
            accessPdirAlt_q <= (regRd || regWr) && isPdirAlt;           // [RQ10]
        end
    end

    sequence s_pin_low;
        !resetPinB;
    endsequence

    sequence s_core_held;
        ##2 !coreResetB_q;
    endsequence

    a_reset_synced: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ2]
        s_pin_low |-> s_core_held)
        else $error("core reset did not follow the pin after two stages");

    a_ptr_low_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ5]
        regWr && regAddr == ADR_DPL && !isMapped && !rstCore
        |=> selPtr[7:0] == $past(regWrData))
        else $error("selected pointer low byte not written");

    a_others_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ5]
        (regWr || bitOp) && (regAddr == ADR_DPL || regAddr == ADR_DPH) && !rstCore
        |=> $stable(otherPtr))
        else $error("unselected pointer changed");

    a_active_follows: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ4]
        regWr && regAddr == ADR_PSEL && !isMapped && !rstCore ##1 !wrStb && !rstCore
        |=> activePointer_q == ptrVal[$past(regWrData[SELW-1:0], 2)])
        else $error("active pointer does not match select");

    a_map_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ7]
        sfrMapSelect_q && !rstCore && !(wrStb && regAddr == ADR_SYSC)
        |=> sfrMapSelect_q)
        else $error("map select cleared without software");

    a_mapped_decode: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ6]
        regRd && sfrMapSelect_q && smap_is_mappable(regAddr)
        |=> accessMapped_q && regRdData_q == RST_ZERO)
        else $error("mapped access not flagged");

    a_std_decode: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ8]
        (regRd || regWr) && !smap_is_mappable(regAddr) |=> !accessMapped_q)
        else $error("unmappable address flagged as mapped");

    a_reset_values: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ12]
        $rose(coreResetB_q) |-> stackPointer_q == RST_SP && pointerSelect_q == '0 &&
            arithResultReg_q == RST_ZERO && systemControl_q == RST_SYSC)
        else $error("core registers not at reset values");

    a_e_capture: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ15]
        $rose(coreResetB_q) |=>
            systemControlTwo_q[SYSC2_E_HI:SYSC2_E_LO] == {2{$past(programEnablePin)}})
        else $error("e bits did not take the program enable level");

    a_fixed_bit: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ11]
        regRd && regAddr == ADR_SYSC && !isMapped |=> regRdData_q[SYSC_FIX_BIT])
        else $error("fixed system control bit reads zero");

    a_bit_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ16]
        bitSet && regAddr == ADR_ACC && !rstCore |=> arithResultReg_q[$past(bitIdx)])
        else $error("single bit set lost");

    sequence s_pin_high;
        resetPinB [*3];
    endsequence

    a_ptr_high_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ5]
        regWr && regAddr == ADR_DPH && !isMapped && !rstCore
        |=> selPtr[PTR_W-1:DATA_W] == $past(regWrData))
        else $error("selected pointer high byte not written");

    a_sync_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ2]
        s_pin_high |=> coreResetB_q)
        else $error("core reset still held after the pin went high");

    a_core_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ12]
        rstCore |=> stackPointer_q == RST_SP && programStatusWord_q == RST_ZERO &&
            auxOperand_q == RST_ZERO && selPtr == '0)
        else $error("core registers left their reset values during reset");

    a_psel_reset: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ13]
        rstCore |=> pointerSelect_q == SELW'(RST_PSEL))
        else $error("pointer select not cleared by reset");

    a_map_reset: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ6]
        rstCore |=> !sfrMapSelect_q)
        else $error("map select not cleared by reset");

    a_sysc_mask: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ11]
        regWr && regAddr == ADR_SYSC && !isMapped && !rstCore
        |=> systemControl_q == (($past(regWrData) & SYSC_RW_MASK) | SYSC_FIX_MASK))
        else $error("system control write not masked");

    a_sysc2_mask: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ14]
        regWr && regAddr == ADR_SYSC2 && !isMapped && !rstCore && !eCapture
        |=> systemControlTwo_q == ($past(regWrData) & SYSC2_RW_MASK))
        else $error("system control two write not masked");

    a_port_direction_map_bit_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ10]
        regRd && regAddr == ADR_PORT_DIRECTION_MAP_BIT_ALT && portDirMapBit
        |=> accessPdirAlt_q && regRdData_q == RST_ZERO)
        else $error("port direction alternate not flagged");

    a_bit_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ16]
        bitClr && regAddr == ADR_PSW && !rstCore |=> !programStatusWord_q[$past(bitIdx)])
        else $error("single bit clear lost");

    a_bit_keeps_rest: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ16]
        bitSet && regAddr == ADR_AUX && !rstCore
        |=> auxOperand_q == ($past(auxOperand_q) | (8'h01 << $past(bitIdx))))
        else $error("single bit set disturbed other bits");

    a_read_sp: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ9]
        regRd && regAddr == ADR_SP && !isMapped
        |=> regRdData_q == $past(stackPointer_q))
        else $error("stack pointer read back wrong");

endmodule // smap_bank

/* src/smap_pkg.sv */
// smap_pkg: constants for the special function register bank
// assumes one 250 MHz clock and byte-wide register addresses
//
// Notes on behaviour
// RQ1 - the reset source holds the reset pin low for at least 12 oscillator periods.
// RQ2 - the reset pin is active low and reaches the bank only through a synchroniser.
// RQ3 - eight independent 16-bit data pointers are kept.
// RQ4 - exactly one pointer is active, chosen by the pointer select register at 92h.
// RQ5 - pointer byte accesses reach only the selected pointer, the others hold.
// RQ6 - map select 0 reaches the standard area, 1 reaches the mapped area, reset 0.
// RQ7 - map select stays set until software clears it.
// RQ8 - only the compare/capture group registers may decode in the mapped area.
// RQ9 - all registers but the program counter and register banks sit in this space.
// RQ10 - shared addresses pick their register by map select or the port direction bit.
// RQ11 - system control sits at b1h and resets to 1010xx01.
// RQ12 - stack pointer resets to 07h; accumulator, aux, status and pointer bytes to 00h.
// RQ13 - the low three pointer select bits reset to zero.
// RQ14 - system control two sits at b2h and resets to 00xxxee0.
// RQ15 - the e bits take the program enable pin level as reset ends.
// RQ16 - registers at d0h, e0h and f0h accept single bit set, clear and read.
package smap_pkg;

    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 8;
    localparam int          BIDX_W         = 3;
    localparam int          PTR_COUNT      = 8;
    localparam int          PTR_W          = 16;
    localparam int          SFR_COUNT      = 103;
    localparam int          RST_HOLD_OSC   = 12;

    localparam logic [7:0]  ADR_SP         = 8'h81;
    localparam logic [7:0]  ADR_DPL        = 8'h82;
    localparam logic [7:0]  ADR_DPH        = 8'h83;
    localparam logic [7:0]  ADR_PSEL       = 8'h92;
    localparam logic [7:0]  ADR_SYSC       = 8'hb1;
    localparam logic [7:0]  ADR_SYSC2      = 8'hb2;
    localparam logic [7:0]  ADR_PORT_DIRECTION_MAP_BIT_ALT   = 8'hbf;
    localparam logic [7:0]  ADR_PSW        = 8'hd0;
    localparam logic [7:0]  ADR_ACC        = 8'he0;
    localparam logic [7:0]  ADR_AUX        = 8'hf0;

    localparam logic [7:0]  RST_SP         = 8'h07;
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  RST_SYSC       = 8'ha1;
    localparam logic [7:0]  RST_SYSC2      = 8'h00;
    localparam logic [2:0]  RST_PSEL       = 3'h0;

    localparam int          SYSC_MAP_BIT   = 4;
    localparam int          SYSC_FIX_BIT   = 5;
    localparam logic [7:0]  SYSC_RW_MASK   = 8'hd3;
    localparam logic [7:0]  SYSC_FIX_MASK  = 8'h20;
    localparam logic [7:0]  SYSC2_RW_MASK  = 8'hc7;
    localparam int          SYSC2_E_LO     = 1;
    localparam int          SYSC2_E_HI     = 2;

    localparam logic [7:0]  MAP_LO0        = 8'hd2;
    localparam logic [7:0]  MAP_HI0        = 8'hd7;
    localparam logic [7:0]  MAP_LO1        = 8'he2;
    localparam logic [7:0]  MAP_HI1        = 8'he7;
    localparam logic [7:0]  MAP_LO2        = 8'hf2;
    localparam logic [7:0]  MAP_HI2        = 8'hf6;

    localparam logic [2:0]  BIT_ADR_LOW    = 3'h0;

    function automatic logic smap_is_mappable(input logic [7:0] a);
        return (a >= MAP_LO0 && a <= MAP_HI0) || (a >= MAP_LO1 && a <= MAP_HI1) ||
               (a >= MAP_LO2 && a <= MAP_HI2);
    endfunction

    function automatic logic smap_is_bit_reg(input logic [7:0] a);
        return (a[2:0] == BIT_ADR_LOW) &&
               (a == ADR_PSW || a == ADR_ACC || a == ADR_AUX);
    endfunction

endpackage

/* src/smap_dptr.sv */
// smap_dptr: one 16-bit data pointer with byte-wide write access
// assumes the owner qualifies the write strobes with the pointer select
`timescale 1ns/100ps
module smap_dptr
    import smap_pkg::*;
#(
    parameter int PW = PTR_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              clrReq,
    input  wire logic              wrLow,
    input  wire logic              wrHigh,
    input  wire logic [DATA_W-1:0] wrData,
    output logic      [PW-1:0]     value
);

    if (PW != 2 * DATA_W) begin : g_bad_width
        $error("smap_dptr: pointer must be two bytes");
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            value <= {RST_ZERO, RST_ZERO};
        end else if (clrReq) begin
            value <= {RST_ZERO, RST_ZERO};                              // [RQ12]
        end else begin
            if (wrLow) begin
                value[DATA_W-1:0] <= wrData;
            end
            if (wrHigh) begin
                value[PW-1:DATA_W] <= wrData;
            end
        end
    end

endmodule // smap_dptr

/* bench/tb.sv */
// tb: self-checking bench for the special function register bank
// assumes smap_bank with default parameters, driven over its plain register port
`timescale 1ns/100ps
module tb;
    import smap_pkg::*;

    logic              ref_clk;
    logic              rst_b;
    logic              resetPinB;
    logic              programEnablePin;
    logic              portDirMapBit;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWr;
    logic              regRd;
    logic              bitSet;
    logic              bitClr;
    logic [BIDX_W-1:0] bitIdx;
    logic [DATA_W-1:0] regRdData_q;
    logic              regRdBit_q;
    logic [PTR_W-1:0]  activePointer_q;
    logic              sfrMapSelect_q;
    logic              accessMapped_q;
    logic              accessPdirAlt_q;
    logic              coreResetB_q;
    int                fail_count;
    int                total_checks;
    logic [7:0]        rstAdr [9] = '{ADR_SP, ADR_DPL, ADR_DPH, ADR_PSEL, ADR_SYSC,
                                      ADR_SYSC2, ADR_PSW, ADR_ACC, ADR_AUX};
    logic [7:0]        bitAdr [3] = '{ADR_PSW, ADR_ACC, ADR_AUX};

    smap_bank i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .resetPinB(resetPinB),
        .programEnablePin(programEnablePin), .portDirMapBit(portDirMapBit),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .bitSet(bitSet), .bitClr(bitClr), .bitIdx(bitIdx), .regRdData_q(regRdData_q),
        .regRdBit_q(regRdBit_q), .activePointer_q(activePointer_q),
        .sfrMapSelect_q(sfrMapSelect_q), .accessMapped_q(accessMapped_q),
        .accessPdirAlt_q(accessPdirAlt_q), .coreResetB_q(coreResetB_q)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // kind 0 write, 1 read, 2 bit set, 3 bit clear; one-cycle strobe
    task automatic acc(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] idx);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        bitIdx <= idx;
        regWr <= (kind == 2'h0);
        regRd <= (kind == 2'h1);
        bitSet <= (kind == 2'h2);
        bitClr <= (kind == 2'h3);
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        bitSet <= 1'b0;
        bitClr <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(2'h0, a, d, 3'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        acc(2'h1, a, 8'h00, 3'h0);
        chk({8'h00, regRdData_q}, {8'h00, exp}, what);
    endtask

    task automatic wait_core(input logic lvl);
        int n;
        n = 0;
        while (coreResetB_q !== lvl && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (coreResetB_q !== lvl) begin
            fail_count++;
            $display("mismatch at %0t: core reset wait ran out", $time);
            tally_and_finish();
        end else begin
            @(posedge ref_clk);
        end
    endtask

    task automatic check_resets(input logic [7:0] sysc2Exp);
        logic [7:0] ev [9];
        ev = '{RST_SP, RST_ZERO, RST_ZERO, RST_ZERO, RST_SYSC, sysc2Exp,
               RST_ZERO, RST_ZERO, RST_ZERO};
        for (int i = 0; i < 9; i++) begin
            rd(rstAdr[i], ev[i], "reset value");
        end
        chk({15'h0, sfrMapSelect_q}, 16'h0000, "map select reset");
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        resetPinB = 1'b1;
        programEnablePin = 1'b1;
        portDirMapBit = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        bitSet = 1'b0;
        bitClr = 1'b0;
        bitIdx = 3'h0;
        fail_count = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        wait_core(1'b1);
        check_resets(8'h06);
        wr(ADR_SYSC2, 8'hff);
        rd(ADR_SYSC2, 8'hc7, "sysc2 writable bits");
        $display("test reset values done");

        for (int i = 0; i < 8; i++) begin
            wr(ADR_PSEL, 8'(i));
            wr(ADR_DPL, 8'h10 + 8'(i));
            wr(ADR_DPH, 8'ha0 + 8'(i));
        end
        for (int i = 7; i >= 0; i--) begin
            wr(ADR_PSEL, 8'hf8 | 8'(i));
            rd(ADR_PSEL, 8'(i), "pointer select");
            rd(ADR_DPL, 8'h10 + 8'(i), "pointer low");
            rd(ADR_DPH, 8'ha0 + 8'(i), "pointer high");
            chk(activePointer_q, {8'ha0 + 8'(i), 8'h10 + 8'(i)}, "active");
        end
        $display("test data pointers done");

        wr(ADR_ACC, 8'h5a);
        rd(MAP_LO0, 8'h00, "standard d2");
        chk({15'h0, accessMapped_q}, 16'h0000, "no map hit");
        wr(ADR_SYSC, 8'hb1);
        chk({15'h0, sfrMapSelect_q}, 16'h0001, "map set");
        rd(MAP_LO0, 8'h00, "mapped d2");
        chk({15'h0, accessMapped_q}, 16'h0001, "map hit d2");
        rd(MAP_HI2, 8'h00, "mapped f6");
        chk({15'h0, accessMapped_q}, 16'h0001, "map hit f6");
        rd(8'he8, 8'h00, "e8 outside");
        chk({15'h0, accessMapped_q}, 16'h0000, "e8 not mapped");
        rd(ADR_ACC, 8'h5a, "acc under map");
        chk({15'h0, accessMapped_q}, 16'h0000, "acc standard");
        chk({15'h0, sfrMapSelect_q}, 16'h0001, "map stays");
        wr(ADR_SYSC, 8'hff);
        rd(ADR_SYSC, 8'hf3, "sysc masks");
        wr(ADR_SYSC, 8'ha1);
        chk({15'h0, sfrMapSelect_q}, 16'h0000, "map cleared");
        $display("test map select done");

        @(posedge ref_clk);
        portDirMapBit <= 1'b1;
        rd(ADR_PORT_DIRECTION_MAP_BIT_ALT, 8'h00, "bf read");
        chk({15'h0, accessPdirAlt_q}, 16'h0001, "port_direction_map_bit alternate");
        @(posedge ref_clk);
        portDirMapBit <= 1'b0;
        rd(ADR_PORT_DIRECTION_MAP_BIT_ALT, 8'h00, "bf read");
        chk({15'h0, accessPdirAlt_q}, 16'h0000, "port_direction_map_bit standard");
        wr(8'h01, 8'h55);
        rd(8'h01, 8'h00, "unmapped address");
        $display("test shared and unmapped done");

        for (int i = 0; i < 3; i++) begin
            wr(bitAdr[i], 8'h00);
            acc(2'h2, bitAdr[i], 8'h00, 3'h7);
            acc(2'h2, bitAdr[i], 8'h00, 3'h0);
            acc(2'h3, bitAdr[i], 8'h00, 3'h0);
            rd(bitAdr[i], 8'h80, "bit set clear");
            acc(2'h1, bitAdr[i], 8'h00, 3'h7);
            chk({15'h0, regRdBit_q}, 16'h0001, "bit read");
        end
        acc(2'h2, ADR_SP, 8'h00, 3'h7);
        rd(ADR_SP, RST_SP, "bit op off target");
        $display("test bit access done");

        wr(ADR_SYSC, 8'hb1);
        wr(ADR_PSEL, 8'h05);
        @(posedge ref_clk);
        programEnablePin <= 1'b0;
        resetPinB <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({15'h0, coreResetB_q}, 16'h0001, "reset synchronised");
        @(posedge ref_clk);
        #1;
        chk({15'h0, coreResetB_q}, 16'h0000, "reset taken");
        repeat (10) @(posedge ref_clk);
        resetPinB <= 1'b1;
        wait_core(1'b1);
        check_resets(8'h00);
        wr(ADR_PSEL, 8'h07);
        rd(ADR_DPL, 8'h00, "pointer seven cleared");
        rd(ADR_DPH, 8'h00, "pointer seven cleared");
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule // tb
